// *** src/pepc_defs.svh ***
// Register offsets, field positions and reset values of the port pad control.
`ifndef PEPC_DEFS_SVH
`define PEPC_DEFS_SVH

`define PEPC_ADDR_W        12
`define PEPC_OFF_ADDR_SEL  12'h000
`define PEPC_OFF_DRIVE     12'h004
`define PEPC_OFF_PULLUP    12'h008
`define PEPC_OFF_INPUT_EN  12'h00c
`define PEPC_OFF_PIN_STAT  12'h010
`define PEPC_SEL_BITS      4
`define PEPC_PORT_BITS     8
`define PEPC_RST_SEL       4'h0
`define PEPC_RST_BYTE      8'h00

`endif

// *** src/pepc_pkg.sv ***
// Types shared by the port pad control files.
package pepc_pkg;

  typedef enum logic [2:0] {
    PEPC_IDLE   = 3'b001,
    PEPC_SETUP  = 3'b010,
    PEPC_ACCESS = 3'b100
  } pepc_apb_state_t;

  typedef logic [31:0] pepc_word_t;

endpackage

// *** src/pepc_pad_cell.sv ***
// One pad's drive, pull-up and input gating.
`timescale 1ns/1ps
module pepc_pad_cell (
  input  wire logic drive_sel,
  input  wire logic port_out,
  input  wire logic port_oe,
  input  wire logic alt_out,
  input  wire logic open_drain,
  input  wire logic pullup_on,
  input  wire logic input_on,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup,
  output logic      core_in
);

  wire logic data_w;
  wire logic en_w;

  // *******************************
  // Source selection and driver
  // *******************************
  assign data_w     = drive_sel ? alt_out : port_out;
  assign en_w       = drive_sel ? 1'b1 : port_oe;
  // Open drain only ever pulls low; a high is left to the pull-up.
  assign pad_out    = open_drain ? 1'b0 : data_w;
  assign pad_oe     = en_w & (open_drain ? ~data_w : 1'b1);
  assign pad_pullup = pullup_on;
  // A blocked input reads zero so that a floating pad cannot toggle logic.
  assign core_in    = input_on & pad_in;

endmodule

// *** src/pepc_top.sv ***
// Pad control for an eight-bit port with APB register access.
`timescale 1ns/1ps
`include "pepc_defs.svh"
// Notes on behaviour
// R1 - A select bit of zero keeps the low pin a port pin, one routes it to address line 20 to 23 in bit order.
// R2 - Each output-type bit gives push-pull when zero and open drain when one.
// R3 - Each pull-up bit turns its pull-up off at zero and on at one, read and write.
// R4 - Each input bit blocks the pin's input at zero and passes it at one, read and write.
// R5 - Unused upper bits of every control register are read-only zero.
// R6 - After reset every select, type, pull-up and input bit is zero.
module pepc_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire pepc_pkg::pepc_word_t    pwdata,
  output pepc_pkg::pepc_word_t         prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [7:0]              port_out,
  input  wire logic [7:0]              port_oe,
  input  wire logic [3:0]              ext_addr_hi,
  input  wire logic [7:0]              pad_in,
  output logic [7:0]                   pad_out,
  output logic [7:0]                   pad_oe,
  output logic [7:0]                   pad_pullup,
  output logic [7:0]                   core_in
);
  import pepc_pkg::*;

  // *******************************
  // Register storage
  // *******************************
  logic [3:0] addr_sel_q;
  logic [3:0] addr_sel_d;
  logic [7:0] open_drain_q;
  logic [7:0] open_drain_d;
  logic [7:0] pullup_q;
  logic [7:0] pullup_d;
  logic [7:0] input_en_q;
  logic [7:0] input_en_d;
  pepc_word_t prdata_q;
  pepc_word_t prdata_d;
  logic       slverr_q;
  logic       slverr_d;

  // *******************************
  // Bus decode
  // *******************************
  wire logic       setup_w;
  wire logic       access_w;
  wire logic       wr_w;
  wire logic       rd_w;
  wire logic       hit_sel;
  wire logic       hit_drv;
  wire logic       hit_pup;
  wire logic       hit_ie;
  wire logic       hit_stat;
  wire logic       hit_any;
  wire pepc_word_t rd_mux;

  // Read data is fetched at the setup edge so that it already stands in the
  // first access cycle; that is what lets pready stay high with no waits.
  // Writes land only at the access edge, when the transfer completes, so a
  // setup cycle that is never followed by penable changes nothing.
  assign setup_w  = clk_en & psel & ~penable;
  assign access_w = clk_en & psel & penable;
  assign wr_w     = access_w & pwrite;
  assign rd_w     = setup_w & ~pwrite;
  assign hit_sel  = paddr == `PEPC_OFF_ADDR_SEL;
  assign hit_drv  = paddr == `PEPC_OFF_DRIVE;
  assign hit_pup  = paddr == `PEPC_OFF_PULLUP;
  assign hit_ie   = paddr == `PEPC_OFF_INPUT_EN;
  assign hit_stat = paddr == `PEPC_OFF_PIN_STAT;
  assign hit_any  = hit_sel | hit_drv | hit_pup | hit_ie | hit_stat;

  assign rd_mux =
    hit_sel  ? {28'h0000000, addr_sel_q}  :  // R5
    hit_drv  ? {24'h000000, open_drain_q} :  // R5
    hit_pup  ? {24'h000000, pullup_q}     :  // R3
    hit_ie   ? {24'h000000, input_en_q}   :  // R4
    hit_stat ? {24'h000000, core_in}      :  // R4
               32'h00000000;

  // Only the low bits are stored, so upper write data is dropped.
  assign addr_sel_d   = (wr_w & hit_sel) ? pwdata[3:0] : addr_sel_q;  // R5
  assign open_drain_d = (wr_w & hit_drv) ? pwdata[7:0] : open_drain_q;
  assign pullup_d     = (wr_w & hit_pup) ? pwdata[7:0] : pullup_q;
  assign input_en_d   = (wr_w & hit_ie)  ? pwdata[7:0] : input_en_q;
  assign prdata_d     = rd_w ? rd_mux : prdata_q;
  assign slverr_d     = setup_w ? ~hit_any : slverr_q;

  // Every control bit changes at the edge that completes its write, and the
  // pads follow within the same cycle. A low clk_en at that edge loses the
  // write, which software must avoid while the enable is gated.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_sel_q   <= `PEPC_RST_SEL;   // R6
      open_drain_q <= `PEPC_RST_BYTE;  // R6
      pullup_q     <= `PEPC_RST_BYTE;  // R6
      input_en_q   <= `PEPC_RST_BYTE;  // R6
      prdata_q     <= 32'h00000000;
      slverr_q     <= 1'b0;
    end else if (clk_en) begin
      addr_sel_q   <= addr_sel_d;
      open_drain_q <= open_drain_d;
      pullup_q     <= pullup_d;
      input_en_q   <= input_en_d;
      prdata_q     <= prdata_d;
      slverr_q     <= slverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = slverr_q & psel & penable;

  // *******************************
  // Pad cells
  // *******************************
  genvar gi;
  generate
    for (gi = 0; gi < `PEPC_PORT_BITS; gi = gi + 1) begin : g_pad
      wire logic sel_w;
      wire logic alt_w;
      wire logic src_w;
      if (gi < `PEPC_SEL_BITS) begin : g_alt
        assign sel_w = addr_sel_q[gi];  // R1
        assign alt_w = ext_addr_hi[gi]; // R1
      end else begin : g_port
        assign sel_w = 1'b0;
        assign alt_w = 1'b0;
      end
      assign src_w = sel_w ? alt_w : port_out[gi];
      pepc_pad_cell u_cell (
        .drive_sel  (sel_w),
        .port_out   (port_out[gi]),
        .port_oe    (port_oe[gi]),
        .alt_out    (alt_w),
        .open_drain (open_drain_q[gi]),  // R2
        .pullup_on  (pullup_q[gi]),      // R3
        .input_on   (input_en_q[gi]),    // R4
        .pad_in     (pad_in[gi]),
        .pad_out    (pad_out[gi]),
        .pad_oe     (pad_oe[gi]),
        .pad_pullup (pad_pullup[gi]),
        .core_in    (core_in[gi])
      );

      // The same checks stand on every pad; src_w is the level the pin is
      // asked to show, before the output type is applied.
      a_pin_sel_drives: assert property (  // R1
        @(posedge pclk) disable iff (!presetn)
        (sel_w && !open_drain_q[gi]) |->
          (pad_oe[gi] && pad_out[gi] == alt_w))
        else $error("Selected pin does not drive its address line.");

      a_pin_pp_follows: assert property (  // R2
        @(posedge pclk) disable iff (!presetn)
        !open_drain_q[gi] |->
          (pad_out[gi] == src_w && pad_oe[gi] == (sel_w | port_oe[gi])))
        else $error("Push-pull pin does not follow its source.");

      a_pin_od_release: assert property (  // R2
        @(posedge pclk) disable iff (!presetn)
        (open_drain_q[gi] && src_w) |-> !pad_oe[gi])
        else $error("Open drain pin does not release a high.");

      a_pin_od_low: assert property (  // R2
        @(posedge pclk) disable iff (!presetn)
        (open_drain_q[gi] && (sel_w || port_oe[gi]) && !src_w) |->
          (pad_oe[gi] && !pad_out[gi]))
        else $error("Open drain pin does not pull low.");

      a_pin_input_gate: assert property (  // R4
        @(posedge pclk) disable iff (!presetn)
        core_in[gi] == (input_en_q[gi] & pad_in[gi]))
        else $error("Input gate does not match its enable.");
    end
  endgenerate

  // *******************************
  // Checks
  // *******************************
  a_sel_routes_addr: assert property (  // R1
    @(posedge pclk) disable iff (!presetn)
    addr_sel_q[2] |-> (pad_out[2] == ext_addr_hi[2] || open_drain_q[2]))
    else $error("Selected pin does not carry its address line.");

  a_sel_keeps_port: assert property (  // R1
    @(posedge pclk) disable iff (!presetn)
    (!addr_sel_q[0] && !open_drain_q[0]) |->
      (pad_out[0] == port_out[0] && pad_oe[0] == port_oe[0]))
    else $error("Unselected pin does not follow the port.");

  a_od_never_high: assert property (  // R2
    @(posedge pclk) disable iff (!presetn)
    (open_drain_q[5] && pad_oe[5]) |-> !pad_out[5])
    else $error("Open drain pin drives high.");

  a_pp_drives_high: assert property (  // R2
    @(posedge pclk) disable iff (!presetn)
    (!open_drain_q[6] && !addr_sel_q[0] && port_oe[6] && port_out[6])
      |-> (pad_oe[6] && pad_out[6]))
    else $error("Push-pull pin fails to drive high.");

  a_pullup_write: assert property (  // R3
    @(posedge pclk) disable iff (!presetn)
    (clk_en && psel && penable && pwrite && paddr == `PEPC_OFF_PULLUP)
      |=> (pad_pullup == $past(pwdata[7:0])))
    else $error("Pull-up write not reflected on pads.");

  a_input_blocked: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    !input_en_q[1] |-> !core_in[1])
    else $error("Blocked input leaks into the device.");

  a_input_passes: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    input_en_q[7] |-> core_in[7] == pad_in[7])
    else $error("Enabled input not passed.");

  a_sel_upper_zero: assert property (  // R5
    @(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == `PEPC_OFF_ADDR_SEL)
      ##1 (psel && penable) |-> prdata[31:4] == 28'h0000000)
    else $error("Select register upper bits not zero.");

  // *******************************
  // Register access checks
  // *******************************
  a_sel_write: assert property (  // R1
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && paddr == `PEPC_OFF_ADDR_SEL)
      |=> (addr_sel_q == $past(pwdata[3:0])))
    else $error("Select write not stored.");

  a_od_write: assert property (  // R2
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && paddr == `PEPC_OFF_DRIVE)
      |=> (open_drain_q == $past(pwdata[7:0])))
    else $error("Output type write not stored.");

  a_ie_write: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && paddr == `PEPC_OFF_INPUT_EN)
      |=> (input_en_q == $past(pwdata[7:0])))
    else $error("Input enable write not stored.");

  a_pullup_read: assert property (  // R3
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && paddr == `PEPC_OFF_PULLUP)
      |=> (prdata == {24'h000000, $past(pad_pullup)}))
    else $error("Pull-up read does not match the pads.");

  a_status_read: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && paddr == `PEPC_OFF_PIN_STAT)
      |=> (prdata == {24'h000000, $past(core_in)}))
    else $error("Pin status read does not match the gated inputs.");

  // Every register but the select one is eight bits wide.
  a_upper_zero: assert property (  // R5
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && paddr != `PEPC_OFF_ADDR_SEL)
      |=> (prdata[31:8] == 24'h000000))
    else $error("Upper read bits not zero.");

  a_unmapped_err: assert property (  // R5
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !hit_any) ##1 (psel && penable) |-> pslverr)
    else $error("Unmapped access not flagged.");

  a_mapped_ok: assert property (  // R5
    @(posedge pclk) disable iff (!presetn)
    (setup_w && hit_any) ##1 (psel && penable) |-> !pslverr)
    else $error("Mapped access flagged as an error.");

  a_read_keeps_bits: assert property (  // R3
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite) |=>
      ($stable(addr_sel_q) && $stable(open_drain_q) &&
       $stable(pullup_q) && $stable(input_en_q)))
    else $error("A read changed a control register.");

  // A low clock enable must leave every stored bit where it was.
  a_freeze_bits: assert property (  // R3
    @(posedge pclk) disable iff (!presetn)
    !clk_en |=>
      ($stable(addr_sel_q) && $stable(open_drain_q) && $stable(pullup_q) &&
       $stable(input_en_q) && $stable(prdata_q) && $stable(slverr_q)))
    else $error("State moved while the clock enable was low.");

  a_reset_clear: assert property (  // R6
    @(posedge pclk)
    $rose(presetn) |-> (addr_sel_q == 4'h0 && open_drain_q == 8'h00 &&
      pullup_q == 8'h00 && input_en_q == 8'h00))
    else $error("Control bits not cleared by reset.");

endmodule

// *** dv/pepc_pin_model.sv ***
// Behavioural model of the eight external pins and their pull-ups.
`timescale 1ns/1ps
module pepc_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  logic [7:0] float_q = 8'h55;
  // A floating pin shows a changing pattern, so a stale level never passes.
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the port pad control.
`timescale 1ns/1ps
module tb;
  import pepc_pkg::*;
  logic        pclk = 0, presetn = 0, clk_en = 1;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, ce;
  logic [11:0] paddr = 12'h000;
  pepc_word_t  pwdata = '0, prdata, rd, wd;
  logic [7:0]  port_out = 8'h00, port_oe = 8'h00, ext_en = 8'h00;
  logic [7:0]  ext_val = 8'h00, pad_in, pad_out, pad_oe, pad_pullup, core_in;
  logic [3:0]  ext_addr_hi = 4'h0;
  logic [7:0]  snap;
  logic [7:0]  sh [4] = '{default: 8'h00};
  int          n_fail = 0, n_compared = 0, seed = 32'h8c98, k, i, r;
  always #2 pclk = ~pclk;
  pepc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_out(port_out),
    .port_oe(port_oe), .ext_addr_hi(ext_addr_hi), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .core_in(core_in));
  pepc_pin_model pins (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input pepc_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    // Pin levels as the slave sees them when it fetches read data.
    snap = pad_in;
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Selected low pins carry the address lines; open drain drives lows only.
  function automatic logic [15:0] exp_pads();
    logic [7:0] selm, src, oe;
    selm = {4'h0, sh[0][3:0]};
    src = (selm & {4'h0, ext_addr_hi}) | (~selm & port_out);
    oe = (selm | port_oe) & ~(sh[1] & src);
    return {oe, src & oe};
  endfunction
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    // The second pass opens with a reset in mid-run, which must clear all.
    for (r = 0; r < 2; r++) begin
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      sh = '{default: 8'h00};
      for (i = 0; i < 5; i++) begin
        apb(12'(4 * i), 1'b0, '0);
        chk(rd, '0);
      end
      for (k = 0; k < 60; k++) begin
        i = (k < 4) ? k : int'($unsigned($random(seed)) % 6);
        wd = (k < 4) ? '1 : $random(seed);
        ce = (k < 4) || (($random(seed) & 3) != 0);
        clk_en <= ce;
        apb(12'(4 * i), 1'b1, wd);
        if (ce && i < 4) sh[i] = wd[7:0] & ((i == 0) ? 8'h0f : 8'hff);
        clk_en <= 1'b1;
        apb(12'(4 * i), 1'b0, '0);
        wd = (i == 4) ? {24'h0, snap & sh[3]} : '0;
        if (i < 4) wd = {24'h0, sh[i]};
        chk(rd, wd);
        chk({31'h0, err}, {31'h0, i == 5});
        port_out <= 8'($random(seed));
        port_oe <= 8'($random(seed));
        ext_addr_hi <= 4'($random(seed));
        ext_en <= 8'($random(seed));
        ext_val <= 8'($random(seed));
        @(posedge pclk);
        chk({16'h0, pad_oe, pad_out & pad_oe}, {16'h0, exp_pads()});
        chk({24'h0, pad_pullup}, {24'h0, sh[2]});
        chk({24'h0, core_in}, {24'h0, pad_in & sh[3]});
      end
    end
    end_of_test;
  end
  initial begin
    #40000;
    n_fail++;
    end_of_test;
  end
endmodule
